// file: design/dscp_cfg.svh
// Constants of the serial control port: widths, field positions, resets.
`ifndef DSCP_CFG_SVH
`define DSCP_CFG_SVH
`define WORD_BITS 16
`define CHANNELS 12
`define GRAY_BITS 6
`define FRAME_EDGES 6'h10
`define CTRL_RESET 16'he000
`define CTRL_CLEAR_BIT 0
`define CTRL_SWITCH_LSB 1
`define CTRL_OPEN_LOAD_BIT 13
`define CTRL_DELAY_BIT 14
`define CTRL_RUN_BIT 15
`define STAT_PREWARN_BIT 0
`define STAT_CHANNEL_LSB 1
`define STAT_SHORT_BIT 13
`define STAT_STANDBY_BIT 14
`define STAT_SUPPLY_BIT 15
`define STAT_SHUTDOWN 16'hffff
`endif

// file: design/dscp_pkg.sv
// Types shared by the serial control port.
package dscp_pkg;
  typedef struct packed {
    logic run_n_standby;
    logic shutdown_delay_select;
    logic open_load_check_enable_n;
    logic [11:0] switches;
    logic status_clear_request;
  } control_s;

  typedef struct packed {
    logic hw_inhibit_n;
    logic thermal_prewarn;
    logic thermal_shutdown;
    logic supply_fault;
    logic [11:0] short_fault;
    logic [11:0] open_load;
  } sense_s;

  typedef enum logic [1:0] {
    FRAME_IDLE = 2'b01,
    FRAME_OPEN = 2'b10
  } frame_state_e;
endpackage

// file: design/driver_serial_control_port.sv
// Serial control and status port of a twelve-channel load driver.
`include "dscp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dscp_sync3
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk)
  begin
    s1 <= d;
    s2 <= s1;
    s3 <= s2;
  end

  // A bit moves only once the last two stages agree on it.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
    end
  end
endmodule

module driver_serial_control_port
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  input wire logic hw_inhibit_n,
  input wire logic thermal_prewarn,
  input wire logic thermal_shutdown,
  input wire logic supply_fault_event,
  input wire logic [11:0] short_event,
  input wire logic [11:0] open_load,
  output logic [11:0] output_on,
  output logic open_load_check_enable_n,
  output logic shutdown_delay_select,
  output logic standby
);
  localparam int W = `WORD_BITS;
  localparam int G = `GRAY_BITS;
  localparam int N = `CHANNELS;

  function automatic logic [G-1:0] to_gray(input logic [G-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  function automatic logic [G-1:0] from_gray(input logic [G-1:0] g);
    logic [G-1:0] b;
    b = g;
    for (int i = G - 2; i >= 0; i--)
    begin
      b[i] = b[i + 1] ^ g[i];
    end
    from_gray = b;
  endfunction

  // Link side. The serial clock stands still outside frames, so the
  // edge counters are cleared from the system side, never by the link.
  logic link_clear;
  logic [W-1:0] shift_in;
  logic [G-1:0] fall_gray;
  logic [G-1:0] rise_gray;

  always_ff @(posedge mclk)
  begin
    link_clear <= rst;
  end

  always_ff @(negedge sclk)
  begin
    if (!chip_select_n)
    begin
      shift_in <= {serial_in, shift_in[W-1:1]};
    end
  end

  always_ff @(negedge sclk or posedge link_clear)
  begin
    if (link_clear)
    begin
      fall_gray <= '0;
    end
    else if (!chip_select_n)
    begin
      fall_gray <= to_gray(from_gray(fall_gray) + 6'h01);
    end
  end

  always_ff @(posedge sclk or posedge link_clear)
  begin
    if (link_clear)
    begin
      rise_gray <= '0;
    end
    else if (!chip_select_n)
    begin
      rise_gray <= to_gray(from_gray(rise_gray) + 6'h01);
    end
  end

  // System side crossings.
  logic cs_n_s;
  logic [G-1:0] fall_gray_s;
  logic [G-1:0] rise_gray_s;
  dscp_pkg::sense_s sense_raw;
  dscp_pkg::sense_s sense;

  assign sense_raw.hw_inhibit_n = hw_inhibit_n;
  assign sense_raw.thermal_prewarn = thermal_prewarn;
  assign sense_raw.thermal_shutdown = thermal_shutdown;
  assign sense_raw.supply_fault = supply_fault_event;
  assign sense_raw.short_fault = short_event;
  assign sense_raw.open_load = open_load;

  dscp_sync3 #(.W(1)) u_sync_cs
  (
    .clk(mclk),
    .rst(1'b0),
    .d(chip_select_n),
    .q(cs_n_s)
  );

  dscp_sync3 #(.W(G)) u_sync_fall
  (
    .clk(mclk),
    .rst(rst),
    .d(fall_gray),
    .q(fall_gray_s)
  );

  dscp_sync3 #(.W(G)) u_sync_rise
  (
    .clk(mclk),
    .rst(rst),
    .d(rise_gray),
    .q(rise_gray_s)
  );

  dscp_sync3 #(.W($bits(dscp_pkg::sense_s))) u_sync_sense
  (
    .clk(mclk),
    .rst(rst),
    .d(sense_raw),
    .q(sense)
  );

  logic cs_n_prev;
  logic cs_fall;
  logic cs_rise;
  logic [G-1:0] fall_bin;
  logic [G-1:0] rise_bin;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cs_n_prev <= 1'b1;
    end
    else
    begin
      cs_n_prev <= cs_n_s;
    end
  end

  assign cs_fall = cs_n_prev & ~cs_n_s;
  assign cs_rise = ~cs_n_prev & cs_n_s;
  assign fall_bin = from_gray(fall_gray_s);
  assign rise_bin = from_gray(rise_gray_s);

  // Frame tracking.
  dscp_pkg::frame_state_e frame_state;
  logic [G-1:0] fall_start;
  logic [G-1:0] rise_start;
  logic frame_good;
  logic apply;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      frame_state <= dscp_pkg::FRAME_IDLE;
    end
    else
    begin
      unique case (frame_state)
        dscp_pkg::FRAME_IDLE:
        begin
          if (cs_fall)
          begin
            frame_state <= dscp_pkg::FRAME_OPEN;
          end
        end
        dscp_pkg::FRAME_OPEN:
        begin
          if (cs_rise)
          begin
            frame_state <= dscp_pkg::FRAME_IDLE;
          end
        end
        default:
        begin
          frame_state <= dscp_pkg::FRAME_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fall_start <= '0;
      rise_start <= '0;
    end
    else if (cs_fall)
    begin
      fall_start <= fall_bin;
      rise_start <= rise_bin;
    end
  end

  // The counter difference also rejects a frame with no edges at all.
  assign frame_good = (6'(fall_bin - fall_start) == `FRAME_EDGES);
  assign apply = cs_rise && frame_state == dscp_pkg::FRAME_OPEN
    && frame_good;

  // Control register. The shift word is read only after chip select has
  // risen and the link clock is idle, so it is quiet while it is taken.
  dscp_pkg::control_s control;
  logic clear_pulse;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      control <= `CTRL_RESET;
    end
    else if (apply)
    begin
      control <= shift_in & ~(16'h0001 << `CTRL_CLEAR_BIT);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      clear_pulse <= 1'b0;
    end
    else
    begin
      clear_pulse <= apply && shift_in[`CTRL_CLEAR_BIT];
    end
  end

  // Sticky fault flags; a new event wins over a clear in the same cycle.
  logic supply_fault_flag;
  logic short_fault_flag;
  logic overtemp_latched;
  logic [N-1:0] short_off;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      supply_fault_flag <= 1'b0;
    end
    else
    begin
      supply_fault_flag <= sense.supply_fault
        | (supply_fault_flag & ~clear_pulse);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      short_off <= '0;
      short_fault_flag <= 1'b0;
    end
    else
    begin
      short_off <= sense.short_fault | (short_off & {N{~clear_pulse}});
      short_fault_flag <= (|sense.short_fault)
        | (short_fault_flag & ~clear_pulse);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      overtemp_latched <= 1'b0;
    end
    else
    begin
      overtemp_latched <= sense.thermal_shutdown
        | (overtemp_latched & ~clear_pulse);
    end
  end

  // Output stage control. Supply faults release the outputs as soon as
  // the supply recovers; overtemperature waits for a clear request.
  logic next_standby;
  assign next_standby = ~control.run_n_standby | ~sense.hw_inhibit_n;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      standby <= 1'b1;
      output_on <= '0;
    end
    else
    begin
      standby <= next_standby;
      output_on <= control.switches & ~short_off
        & {N{~next_standby & ~sense.supply_fault
        & ~overtemp_latched}};
    end
  end

  assign open_load_check_enable_n =
    control.open_load_check_enable_n;
  assign shutdown_delay_select = control.shutdown_delay_select;

  // Live status word.
  logic [W-1:0] status_now;
  logic open_load_mode;
  assign open_load_mode = ~control.open_load_check_enable_n;

  always_comb
  begin
    status_now = '0;
    status_now[`STAT_PREWARN_BIT] = sense.thermal_prewarn;
    for (int i = 0; i < N; i++)
    begin
      // A channel that is switched on leaves open-load checking.
      status_now[`STAT_CHANNEL_LSB + i] =
        (open_load_mode && !output_on[i]) ? sense.open_load[i]
        : output_on[i];
    end
    status_now[`STAT_SHORT_BIT] = short_fault_flag;
    status_now[`STAT_STANDBY_BIT] = standby;
    status_now[`STAT_SUPPLY_BIT] = supply_fault_flag;
    if (overtemp_latched)
    begin
      status_now = `STAT_SHUTDOWN;
    end
  end

  // Serial output. The bit follows each rising serial edge after the
  // three-stage crossing, well inside the half period at 2 MHz.
  logic [W-1:0] snapshot;
  logic [G-1:0] out_index;
  assign out_index = 6'(rise_bin - rise_start);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      snapshot <= '0;
    end
    else if (cs_fall)
    begin
      snapshot <= status_now;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      serial_out <= 1'b0;
    end
    else if (cs_fall)
    begin
      serial_out <= status_now[`STAT_PREWARN_BIT];
    end
    else if (frame_state == dscp_pkg::FRAME_OPEN && !cs_rise)
    begin
      serial_out <= (out_index < 6'(W)) ? snapshot[out_index[3:0]]
        : 1'b0;
    end
    else
    begin
      serial_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      serial_out_oe_n <= 1'b1;
    end
    else
    begin
      serial_out_oe_n <= cs_n_s;
    end
  end
endmodule

`default_nettype wire

// file: sim/dscp_host.sv
// Host model that frames words over the serial link.
`timescale 1ns/1ps
`default_nettype none
module dscp_host
(
  output logic sclk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  initial
  begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // A gap of 500 keeps the clock under 2 MHz; 0 gives a 15 ns period.
  task automatic frame(input logic [15:0] tx, input int edges,
    input int gap, output logic [15:0] rx);
    rx = 16'h0000;
    chip_select_n = 1'b0;
    #300;
    for (int k = 0; k < edges; k++)
    begin
      rx[k % 16] = serial_out;
      serial_in = tx[k % 16];
      #5.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
      #2 serial_in = ~serial_in;
      #(gap);
    end
    if (edges == 0)
    begin
      rx[0] = serial_out;
    end
    #300 chip_select_n = 1'b1;
    serial_in = 1'b0;
    #400;
  endtask
endmodule
`default_nettype wire

// file: sim/dscp_port_sva.sv
// Pin-level assertions of the serial control port.
`timescale 1ns/1ps
`default_nettype none
module dscp_port_sva
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic hw_inhibit_n,
  input wire logic thermal_shutdown,
  input wire logic supply_fault_event,
  input wire logic [11:0] short_event,
  input wire logic [11:0] output_on,
  input wire logic open_load_check_enable_n,
  input wire logic shutdown_delay_select,
  input wire logic standby
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence frame_start;
    $fell(chip_select_n);
  endsequence
  sequence frame_held;
    !chip_select_n [*8];
  endsequence
  oe_release_a: assert property (
    chip_select_n [*8] |-> serial_out_oe_n)
    else $error("data out driven while deselected");
  oe_drive_a: assert property (
    frame_start |-> ##[2:6] !serial_out_oe_n)
    else $error("data out not driven after select");
  out_quiet_a: assert property (
    serial_out_oe_n |-> !serial_out)
    else $error("data out moves while released");
  reset_value_a: assert property (disable iff (1'b0) rst |=>
    output_on == 12'h000 && open_load_check_enable_n
    && shutdown_delay_select && standby) else $error("bad reset value");
  ctrl_hold_a: assert property (frame_held |-> $stable(output_on)
    && $stable(shutdown_delay_select) && $stable(open_load_check_enable_n))
    else $error("control moved inside frame");
  hw_inhibit_a: assert property (
    !hw_inhibit_n [*8] |-> standby)
    else $error("inhibit pin ignored");
  short_off_a: assert property (
    short_event[0] [*8] |-> !output_on[0])
    else $error("shorted output stays on");
  hot_off_a: assert property (
    thermal_shutdown [*8] |-> output_on == 12'h000)
    else $error("outputs on in shutdown");
  supply_off_a: assert property (
    supply_fault_event [*8] |-> !(|output_on))
    else $error("outputs on in supply fault");
endmodule
bind driver_serial_control_port dscp_port_sva u_sva
(
  .mclk(mclk), .rst(rst), .chip_select_n(chip_select_n),
  .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
  .hw_inhibit_n(hw_inhibit_n), .thermal_shutdown(thermal_shutdown),
  .supply_fault_event(supply_fault_event), .short_event(short_event),
  .output_on(output_on), .open_load_check_enable_n(open_load_check_enable_n),
  .shutdown_delay_select(shutdown_delay_select), .standby(standby)
);
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench of the serial control port and its host.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hw_inhibit_n = 1'b1;
  logic thermal_prewarn = 1'b1;
  logic thermal_shutdown = 1'b0;
  logic supply_fault_event = 1'b0;
  logic [11:0] short_event = 12'h000;
  logic [11:0] open_load = 12'h800;
  logic [11:0] output_on;
  logic open_load_check_enable_n;
  logic shutdown_delay_select;
  logic standby;
  logic serial_out;
  logic serial_out_oe_n;
  logic [15:0] rx;
  wire logic sclk;
  wire logic chip_select_n;
  wire logic serial_in;
  // No other device shares the return line, so a released line floats.
  wire logic data_line = serial_out_oe_n ? 1'bz : serial_out;
  int fail_count = 0;
  int check_count = 0;
  always #10 mclk = ~mclk;
  driver_serial_control_port u_driver_serial_control_port
  (
    .mclk(mclk), .rst(rst), .sclk(sclk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .hw_inhibit_n(hw_inhibit_n),
    .thermal_prewarn(thermal_prewarn), .thermal_shutdown(thermal_shutdown),
    .supply_fault_event(supply_fault_event), .short_event(short_event),
    .open_load(open_load), .output_on(output_on),
    .open_load_check_enable_n(open_load_check_enable_n),
    .shutdown_delay_select(shutdown_delay_select), .standby(standby)
  );
  dscp_host u_dscp_host
  (
    .sclk(sclk), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .serial_out(data_line)
  );
  function automatic logic [15:0] outs();
    return {1'b0, standby, shutdown_delay_select, open_load_check_enable_n,
      output_on};
  endfunction
  task automatic compare(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic xfer(input logic [15:0] tx, input logic [15:0] want);
    u_dscp_host.frame(tx, 16, 500, rx);
    compare(rx, want);
    settle(1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // The watchdog lies about ten times above the length of one run.
  initial
  begin
    #1ms;
    fail_count++;
    tally_and_finish();
  end
  // Channel 11 high side reads open load whenever open-load checking is on and it is switched off.
  initial
  begin
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    compare(outs(), 16'h7000);
    settle(10);
    compare(outs(), 16'h3000);
    xfer(16'ha006, 16'h0001);
    compare(outs(), 16'h1003);
    xfer(16'h4000, 16'h0007);
    compare(outs(), 16'h6000);
    xfer(16'h8002, 16'h5001);
    compare(outs(), 16'h0001);
    $display("test settings done");
    u_dscp_host.frame(16'h8006, 0, 500, rx);
    compare(rx, 16'h0001);
    for (int e = 15; e <= 17; e += 2)
    begin
      u_dscp_host.frame(16'h8006, e, 0, rx);
      compare(outs(), 16'h0001);
    end
    u_dscp_host.frame(16'h8006, 16, 0, rx);
    compare(outs(), 16'h0003);
    $display("test framing done");
    settle(1);
    hw_inhibit_n = 1'b0;
    settle(8);
    compare(outs(), 16'h4000);
    hw_inhibit_n = 1'b1;
    settle(8);
    short_event = 12'h001;
    settle(8);
    short_event = 12'h000;
    settle(8);
    compare(outs(), 16'h0002);
    xfer(16'h8007, 16'h3005);
    compare(outs(), 16'h0003);
    xfer(16'h8006, 16'h1007);
    $display("test short done");
    thermal_shutdown = 1'b1;
    settle(8);
    compare(outs(), 16'h0000);
    xfer(16'h8006, 16'hffff);
    thermal_shutdown = 1'b0;
    settle(8);
    xfer(16'h8007, 16'hffff);
    compare(outs(), 16'h0003);
    supply_fault_event = 1'b1;
    settle(8);
    compare(outs(), 16'h0000);
    xfer(16'h8006, 16'h9001);
    supply_fault_event = 1'b0;
    settle(8);
    compare(outs(), 16'h0003);
    xfer(16'h8007, 16'h9007);
    xfer(16'h8006, 16'h1007);
    $display("test faults done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
